// >>> dpcs_pkg.sv
package dpcs_pkg;

	// ----------------------------------------
	// Register indices (address bits [3:2])
	// ----------------------------------------
	localparam logic [1:0] DPCS_IDX_ID = 2'h0;
	localparam logic [1:0] DPCS_IDX_CSR_SCAN = 2'h1;
	localparam logic [1:0] DPCS_IDX_CSR_SERIAL = 2'h0;
	localparam logic [1:0] DPCS_IDX_SELECT = 2'h2;
	localparam logic [1:0] DPCS_IDX_READ_BUFFER = 2'h3;
	localparam logic [3:0] DPCS_BANK_CSR = 4'h0;

	// ----------------------------------------
	// Control/status field positions
	// ----------------------------------------
	localparam int DPCS_SYS_ACK_BIT = 31;
	localparam int DPCS_SYS_REQ_BIT = 30;
	localparam int DPCS_DBG_ACK_BIT = 29;
	localparam int DPCS_DBG_REQ_BIT = 28;
	localparam int DPCS_RST_ACK_BIT = 27;
	localparam int DPCS_RST_REQ_BIT = 26;
	localparam int DPCS_TRN_CNT_LSB = 12;
	localparam int DPCS_MASK_LSB = 8;
	localparam int DPCS_WDATA_ERR_BIT = 7;
	localparam int DPCS_READ_OK_BIT = 6;
	localparam int DPCS_STICKY_ERR_BIT = 5;
	localparam int DPCS_STICKY_CMP_BIT = 4;
	localparam int DPCS_TRN_MODE_LSB = 2;
	localparam int DPCS_STICKY_ORUN_BIT = 1;
	localparam int DPCS_ORUN_EN_BIT = 0;

	// ----------------------------------------
	// Select field positions
	// ----------------------------------------
	localparam int DPCS_AP_SEL_LSB = 24;
	localparam int DPCS_AP_BANK_LSB = 4;
	localparam int DPCS_DP_BANK_LSB = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [11:0] DPCS_TRN_CNT_RST = 12'h000;
	localparam logic [3:0] DPCS_MASK_RST = 4'h0;
	localparam logic [1:0] DPCS_TRN_MODE_RST = 2'h0;
	localparam logic [7:0] DPCS_AP_SEL_RST = 8'h00;
	localparam logic [3:0] DPCS_AP_BANK_RST = 4'h0;
	localparam logic [3:0] DPCS_DP_BANK_RST = 4'h0;
	localparam logic [31:0] DPCS_LAST_READ_RST = 32'h0000_0000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic link_clk;
		logic valid;
		logic write;
		logic ap_access;
		logic [1:0] index;
		logic [31:0] wdata;
		logic dp_access_ir;
	} dpcs_link_s;

	typedef struct packed {
		logic system_power_ack;
		logic debug_power_ack;
		logic debug_reset_ack;
	} dpcs_ack_s;

endpackage

// >>> dpcs_top.sv
// Notes on behaviour
// RULE1 - Power-up and debug-reset request bits reset to 0, acknowledges sit one bit above.
// RULE2 - Twelve-bit transaction counter is writable; debugger must load it before use.
// RULE3 - Four-bit byte-lane mask is writable and excludes bytes in pushed compares.
// RULE4 - Serial variant sets write-data-error on parity or framing fault in write data.
// RULE5 - Write-data-error also sets when an accepted write is dropped before the access port.
// RULE6 - Write-data-error resets to 0 and clears only through the abort clear field.
// RULE7 - Scan variant reads write-data-error and read-OK positions as zero.
// RULE8 - Serial read-OK shows whether the last access port or buffer read was OK.
// RULE9 - Sticky error sets when an access port transaction returns an error.
// RULE10 - Scan variant clears sticky flags by writing 1; serial clears via abort fields.
// RULE11 - Sticky compare sets when a pushed compare or verify finds a match.
// RULE12 - Two-bit transfer mode field is writable and steers access port operations.
// RULE13 - Sticky overrun sets on overrun only while overrun detection is enabled.
// RULE14 - Overrun detection enable bit is writable and resets to 0.
// RULE15 - Powerup reset drives the sticky error flag low.
// RULE16 - Select register picks access port, its four-word window and serial bank.
// RULE17 - Scan variant: select is read-write at 0x8 under the port access instruction.
// RULE18 - Serial variant: select is write-only at 0b10 whatever the bank selection.
// RULE19 - Serial variant: control/status reachable only while bank selection is zero.
// RULE20 - Serial read buffer returns last access port read with no new transaction.
// RULE21 - Request bits drive the system controller; its acknowledges show in status.
module dpcs_top #(
	parameter bit SERIAL_VARIANT = 1'b1
) (
	input wire logic clk_sys_in, // System clock, 20 MHz
	input wire logic sys_rst_in, // Powerup reset, synchronous, active high
	input wire logic link_clk_in, // Debugger link clock, sampled
	input wire logic link_valid_in, // Register access present
	input wire logic link_write_in, // 1 write, 0 read
	input wire logic access_or_port_flag_in, // 1 access port, 0 debug port
	input wire logic [1:0] link_index_in, // Register index, address bits [3:2]
	input wire logic [31:0] link_wdata_in, // Write data
	input wire logic port_access_instruction_in, // Scan instruction register holds port access
	input wire logic system_power_ack_in, // Acknowledge from system controller
	input wire logic debug_power_ack_in, // Acknowledge from system controller
	input wire logic debug_reset_ack_in, // Acknowledge from system controller
	input wire logic ap_resp_valid_in, // Access port transaction finished
	input wire logic ap_resp_read_in, // Finished transaction was a read
	input wire logic ap_resp_error_in, // Finished transaction returned an error
	input wire logic [31:0] ap_resp_rdata_in, // Read data of finished transaction
	input wire logic compare_match_in, // Pushed compare or verify matched
	input wire logic overrun_in, // Overrun seen by the link
	input wire logic wdata_fault_in, // Parity or framing fault in write data phase
	input wire logic write_dropped_in, // Accepted write discarded before access port
	input wire logic abort_write_error_clear_in, // Abort clear, write-data-error
	input wire logic abort_sticky_error_clear_in, // Abort clear, sticky error
	input wire logic abort_sticky_compare_clear_in, // Abort clear, sticky compare
	input wire logic abort_overrun_clear_in, // Abort clear, sticky overrun
	output logic system_power_req_out, // Request to system controller
	output logic debug_power_req_out, // Request to system controller
	output logic debug_reset_req_out, // Request to system controller
	output logic [11:0] transaction_counter_out, // Transaction counter
	output logic [3:0] byte_lane_mask_out, // Byte-lane mask
	output logic [1:0] transfer_mode_out, // Transfer mode
	output logic overrun_detect_enable_out, // Overrun detection enabled
	output logic [7:0] ap_select_out, // Current access port
	output logic [3:0] ap_bank_out, // Access port register window
	output logic [3:0] port_bank_select_out, // Debug port register bank
	output logic resp_valid_out, // Read or write answered, one cycle
	output logic [31:0] resp_rdata_out // Read data, held until next read answer
);

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	dpcs_pkg::dpcs_link_s link_meta_reg;
	dpcs_pkg::dpcs_link_s link_sync_reg;
	logic link_clk_prev_reg;
	dpcs_pkg::dpcs_ack_s ack_meta_reg;
	dpcs_pkg::dpcs_ack_s ack_sync_reg;
	dpcs_pkg::dpcs_link_s link_raw;

	assign link_raw = '{link_clk: link_clk_in, valid: link_valid_in, write: link_write_in,
		ap_access: access_or_port_flag_in, index: link_index_in, wdata: link_wdata_in,
		dp_access_ir: port_access_instruction_in};

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			link_meta_reg <= '0;
			link_sync_reg <= '0;
			link_clk_prev_reg <= 1'b0;
		end else begin
			link_meta_reg <= link_raw;
			link_sync_reg <= link_meta_reg;
			link_clk_prev_reg <= link_sync_reg.link_clk;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			ack_meta_reg <= '0;
			ack_sync_reg <= '0;
		end else begin
			ack_meta_reg <= '{system_power_ack: system_power_ack_in,
				debug_power_ack: debug_power_ack_in, debug_reset_ack: debug_reset_ack_in};
			ack_sync_reg <= ack_meta_reg;
		end
	end

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	logic link_edge;
	logic take;
	logic wr_take;
	logic rd_take;
	logic csr_hit;
	logic select_hit;
	logic rdbuf_hit;

	// Rising edge of the link clock carries one register access
	assign link_edge = link_sync_reg.link_clk & ~link_clk_prev_reg;
	assign take = link_edge & link_sync_reg.valid & ~link_sync_reg.ap_access;
	assign wr_take = take & link_sync_reg.write;
	assign rd_take = take & ~link_sync_reg.write;

	function automatic logic dpcs_hit(input logic [1:0] index, input logic [1:0] want,
		input logic serial_only, input logic scan_only, input logic ir_ok);
		logic ok;
		ok = (index == want);
		if (serial_only && !SERIAL_VARIANT) begin
			ok = 1'b0;
		end else if (scan_only && SERIAL_VARIANT) begin
			ok = 1'b0;
		end else if (!SERIAL_VARIANT && !ir_ok) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	always_comb begin
		if (SERIAL_VARIANT) begin
			csr_hit = dpcs_hit(link_sync_reg.index, dpcs_pkg::DPCS_IDX_CSR_SERIAL, 1'b1, 1'b0,
				1'b1) && (port_bank_select_out == dpcs_pkg::DPCS_BANK_CSR); // RULE19
		end else begin
			csr_hit = dpcs_hit(link_sync_reg.index, dpcs_pkg::DPCS_IDX_CSR_SCAN, 1'b0, 1'b1,
				link_sync_reg.dp_access_ir);
		end
	end

	// Select: any bank on the serial side, instruction-gated on the scan side
	assign select_hit = dpcs_hit(link_sync_reg.index, dpcs_pkg::DPCS_IDX_SELECT, 1'b0, 1'b0,
		link_sync_reg.dp_access_ir); // RULE17 RULE18
	assign rdbuf_hit = dpcs_hit(link_sync_reg.index, dpcs_pkg::DPCS_IDX_READ_BUFFER, 1'b1, 1'b0,
		1'b1);

	logic csr_wr;
	logic scan_w1c;
	assign csr_wr = wr_take & csr_hit;
	assign scan_w1c = csr_wr & ~SERIAL_VARIANT;

	// ----------------------------------------
	// Power and reset requests
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			system_power_req_out <= 1'b0; // RULE1
			debug_power_req_out <= 1'b0; // RULE1
			debug_reset_req_out <= 1'b0; // RULE1
		end else if (csr_wr) begin
			system_power_req_out <= link_sync_reg.wdata[dpcs_pkg::DPCS_SYS_REQ_BIT]; // RULE21
			debug_power_req_out <= link_sync_reg.wdata[dpcs_pkg::DPCS_DBG_REQ_BIT]; // RULE21
			debug_reset_req_out <= link_sync_reg.wdata[dpcs_pkg::DPCS_RST_REQ_BIT]; // RULE21
		end
	end

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			transaction_counter_out <= dpcs_pkg::DPCS_TRN_CNT_RST;
			byte_lane_mask_out <= dpcs_pkg::DPCS_MASK_RST;
			transfer_mode_out <= dpcs_pkg::DPCS_TRN_MODE_RST;
			overrun_detect_enable_out <= 1'b0; // RULE14
		end else if (csr_wr) begin
			transaction_counter_out <=
				link_sync_reg.wdata[dpcs_pkg::DPCS_TRN_CNT_LSB +: 12]; // RULE2
			byte_lane_mask_out <= link_sync_reg.wdata[dpcs_pkg::DPCS_MASK_LSB +: 4]; // RULE3
			transfer_mode_out <= link_sync_reg.wdata[dpcs_pkg::DPCS_TRN_MODE_LSB +: 2]; // RULE12
			overrun_detect_enable_out <= link_sync_reg.wdata[dpcs_pkg::DPCS_ORUN_EN_BIT]; // RULE14
		end
	end

	// ----------------------------------------
	// Select register
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			ap_select_out <= dpcs_pkg::DPCS_AP_SEL_RST;
			ap_bank_out <= dpcs_pkg::DPCS_AP_BANK_RST;
			port_bank_select_out <= dpcs_pkg::DPCS_DP_BANK_RST;
		end else if (wr_take && select_hit) begin
			ap_select_out <= link_sync_reg.wdata[dpcs_pkg::DPCS_AP_SEL_LSB +: 8]; // RULE16
			ap_bank_out <= link_sync_reg.wdata[dpcs_pkg::DPCS_AP_BANK_LSB +: 4]; // RULE16
			// Bank field exists only on the serial side
			port_bank_select_out <= SERIAL_VARIANT ?
				link_sync_reg.wdata[dpcs_pkg::DPCS_DP_BANK_LSB +: 4] :
				dpcs_pkg::DPCS_DP_BANK_RST; // RULE16
		end
	end

	// ----------------------------------------
	// Sticky flags (set wins over clear)
	// ----------------------------------------
	logic sticky_error_reg;
	logic sticky_compare_reg;
	logic sticky_overrun_reg;
	logic write_data_error_reg;
	logic read_ok_flag_reg;
	logic clr_err;
	logic clr_cmp;
	logic clr_orun;

	always_comb begin
		if (SERIAL_VARIANT) begin
			clr_err = abort_sticky_error_clear_in; // RULE10
			clr_cmp = abort_sticky_compare_clear_in; // RULE10
			clr_orun = abort_overrun_clear_in; // RULE10
		end else begin
			clr_err = scan_w1c & link_sync_reg.wdata[dpcs_pkg::DPCS_STICKY_ERR_BIT]; // RULE10
			clr_cmp = scan_w1c & link_sync_reg.wdata[dpcs_pkg::DPCS_STICKY_CMP_BIT]; // RULE10
			clr_orun = scan_w1c & link_sync_reg.wdata[dpcs_pkg::DPCS_STICKY_ORUN_BIT]; // RULE10
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sticky_error_reg <= 1'b0; // RULE15
		end else if (ap_resp_valid_in && ap_resp_error_in) begin
			sticky_error_reg <= 1'b1; // RULE9
		end else if (clr_err) begin
			sticky_error_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sticky_compare_reg <= 1'b0;
		end else if (compare_match_in) begin
			sticky_compare_reg <= 1'b1; // RULE11
		end else if (clr_cmp) begin
			sticky_compare_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sticky_overrun_reg <= 1'b0;
		end else if (overrun_in && overrun_detect_enable_out) begin
			sticky_overrun_reg <= 1'b1; // RULE13
		end else if (clr_orun) begin
			sticky_overrun_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			write_data_error_reg <= 1'b0; // RULE6
		end else if (SERIAL_VARIANT && wdata_fault_in) begin
			write_data_error_reg <= 1'b1; // RULE4
		end else if (SERIAL_VARIANT && write_dropped_in) begin
			write_data_error_reg <= 1'b1; // RULE5
		end else if (abort_write_error_clear_in) begin
			write_data_error_reg <= 1'b0; // RULE6
		end
	end

	// ----------------------------------------
	// Read buffer and read-OK
	// ----------------------------------------
	logic [31:0] last_read_reg;
	logic last_read_ok_reg;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			last_read_reg <= dpcs_pkg::DPCS_LAST_READ_RST;
			last_read_ok_reg <= 1'b0;
		end else if (ap_resp_valid_in && ap_resp_read_in) begin
			last_read_reg <= ap_resp_rdata_in; // RULE20
			last_read_ok_reg <= ~ap_resp_error_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			read_ok_flag_reg <= 1'b0; // RULE8
		end else if (SERIAL_VARIANT && ap_resp_valid_in && ap_resp_read_in) begin
			read_ok_flag_reg <= ~ap_resp_error_in; // RULE8
		end else if (rd_take && rdbuf_hit) begin
			read_ok_flag_reg <= last_read_ok_reg; // RULE8
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [31:0] csr_value;
	logic [31:0] rdata_next;

	always_comb begin
		csr_value = '0;
		csr_value[dpcs_pkg::DPCS_SYS_ACK_BIT] = ack_sync_reg.system_power_ack; // RULE21
		csr_value[dpcs_pkg::DPCS_SYS_REQ_BIT] = system_power_req_out;
		csr_value[dpcs_pkg::DPCS_DBG_ACK_BIT] = ack_sync_reg.debug_power_ack; // RULE21
		csr_value[dpcs_pkg::DPCS_DBG_REQ_BIT] = debug_power_req_out;
		csr_value[dpcs_pkg::DPCS_RST_ACK_BIT] = ack_sync_reg.debug_reset_ack; // RULE21
		csr_value[dpcs_pkg::DPCS_RST_REQ_BIT] = debug_reset_req_out;
		csr_value[dpcs_pkg::DPCS_TRN_CNT_LSB +: 12] = transaction_counter_out;
		csr_value[dpcs_pkg::DPCS_MASK_LSB +: 4] = byte_lane_mask_out;
		// Scan side leaves these two positions at zero
		csr_value[dpcs_pkg::DPCS_WDATA_ERR_BIT] = SERIAL_VARIANT & write_data_error_reg; // RULE7
		csr_value[dpcs_pkg::DPCS_READ_OK_BIT] = SERIAL_VARIANT & read_ok_flag_reg; // RULE7
		csr_value[dpcs_pkg::DPCS_STICKY_ERR_BIT] = sticky_error_reg;
		csr_value[dpcs_pkg::DPCS_STICKY_CMP_BIT] = sticky_compare_reg;
		csr_value[dpcs_pkg::DPCS_TRN_MODE_LSB +: 2] = transfer_mode_out;
		csr_value[dpcs_pkg::DPCS_STICKY_ORUN_BIT] = sticky_overrun_reg;
		csr_value[dpcs_pkg::DPCS_ORUN_EN_BIT] = overrun_detect_enable_out;
	end

	always_comb begin
		rdata_next = '0;
		if (csr_hit) begin
			rdata_next = csr_value;
		end else if (select_hit && !SERIAL_VARIANT) begin
			rdata_next[dpcs_pkg::DPCS_AP_SEL_LSB +: 8] = ap_select_out; // RULE17
			rdata_next[dpcs_pkg::DPCS_AP_BANK_LSB +: 4] = ap_bank_out; // RULE17
		end else if (rdbuf_hit) begin
			rdata_next = last_read_reg; // RULE20
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			resp_valid_out <= 1'b0;
			resp_rdata_out <= '0;
		end else begin
			resp_valid_out <= take;
			if (rd_take) begin
				resp_rdata_out <= rdata_next;
			end
		end
	end

endmodule

// >>> dpcs_top_asserts.sv
module dpcs_top_asserts (
	input wire logic clk_sys_in, // System clock
	input wire logic sys_rst_in, // Powerup reset
	input wire logic link_clk_in, // Link clock
	input wire logic link_valid_in, // Access present
	input wire logic access_or_port_flag_in, // Access port access
	input wire logic system_power_req_out, // Request
	input wire logic debug_power_req_out, // Request
	input wire logic debug_reset_req_out, // Request
	input wire logic [11:0] transaction_counter_out, // Counter
	input wire logic [3:0] byte_lane_mask_out, // Lane mask
	input wire logic [1:0] transfer_mode_out, // Mode
	input wire logic overrun_detect_enable_out, // Overrun enable
	input wire logic [7:0] ap_select_out, // Access port
	input wire logic [3:0] ap_bank_out, // Window
	input wire logic [3:0] port_bank_select_out, // Bank
	input wire logic resp_valid_out, // Answer pulse
	input wire logic [31:0] resp_rdata_out // Read data
);
	wire logic [21:0] ctrl_fields;
	wire logic [15:0] sel_fields;
	assign ctrl_fields = {system_power_req_out, debug_power_req_out, debug_reset_req_out,
		transaction_counter_out, byte_lane_mask_out, transfer_mode_out, overrun_detect_enable_out};
	assign sel_fields = {ap_select_out, ap_bank_out, port_bank_select_out};
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	sequence link_take;
		$rose(link_clk_in) && link_valid_in && !access_or_port_flag_in;
	endsequence
	sequence link_ap;
		$rose(link_clk_in) && link_valid_in && access_or_port_flag_in;
	endsequence
	chk_reset_reqs_low: assert property ($fell(sys_rst_in) |-> ctrl_fields == 22'h0)
		else $error("control fields not zero after reset");
	chk_reset_orun_off: assert property ($fell(sys_rst_in) |-> !overrun_detect_enable_out)
		else $error("overrun enable set after reset");
	chk_reset_select_zero: assert property ($fell(sys_rst_in) |-> sel_fields == 16'h0)
		else $error("select fields not zero after reset");
	chk_resp_one_cycle: assert property (resp_valid_out |=> !resp_valid_out)
		else $error("answer pulse longer than one cycle");
	chk_answer_latency: assert property (link_take |-> ##[2:6] resp_valid_out)
		else $error("taken access not answered in time");
	chk_ap_ignored: assert property (link_ap |-> ##1 !resp_valid_out [*6])
		else $error("access port access answered");
	chk_ctrl_hold: assert property ($changed(ctrl_fields) |-> resp_valid_out)
		else $error("control fields changed without an access");
	chk_select_hold: assert property ($changed(sel_fields) |-> resp_valid_out)
		else $error("select fields changed without an access");
	chk_rdata_hold: assert property (!resp_valid_out |-> $stable(resp_rdata_out))
		else $error("read data changed without an answer");
endmodule

// >>> dpcs_dbg.sv
module dpcs_dbg (
	input wire logic clk_sys_in, // System clock
	input wire logic resp_valid_out, // Answer pulse
	input wire logic [31:0] resp_rdata_out, // Read data
	output logic link_clk_out, // Link clock, still outside frames
	output logic link_valid_out, // Access present
	output logic link_write_out, // Write
	output logic ap_flag_out, // Access port access
	output logic [1:0] idx_out, // Register index
	output logic [31:0] wdata_out // Write data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		link_clk_out = 1'b0;
		link_valid_out = 1'b0;
		link_write_out = 1'b0;
		ap_flag_out = 1'b0;
		idx_out = 2'h0;
		wdata_out = 32'h0;
	end
	// One access per link rising edge; read data left unknown if no answer comes
	task automatic xfer(input logic w, input logic ap, input logic [1:0] idx,
		input logic [31:0] d, output logic [31:0] rd);
		rd = 32'hXXXXXXXX;
		@(negedge clk_sys_in);
		link_valid_out = 1'b1;
		link_write_out = w;
		ap_flag_out = ap;
		idx_out = idx;
		wdata_out = d;
		repeat (3) @(negedge clk_sys_in);
		link_clk_out = 1'b1;
		// High for four system cycles, low for four: a 400 ns link period
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_sys_in);
			if (resp_valid_out === 1'b1) begin
				rd = resp_rdata_out;
			end
		end
		link_clk_out = 1'b0;
		link_valid_out = 1'b0;
		wdata_out = ~wdata_out;
		idx_out = ~idx_out;
	endtask
endmodule

// >>> tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [7:0] ev = 8'h00;
	logic [2:0] ack = 3'h0;
	logic apv = 1'b0;
	logic apr = 1'b0;
	logic ape = 1'b0;
	logic [31:0] aprd = 32'h0;
	logic lclk, lval, lwr, lap;
	logic [1:0] lidx;
	logic [31:0] lwd, rdata, d;
	logic scan_ir = 1'b1;
	logic [31:0] srd;
	logic spr, dpr, drr, ooe, rv;
	logic [11:0] cnt;
	logic [3:0] mask, apb, pbs;
	logic [1:0] mode;
	logic [7:0] aps;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	initial begin
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	dpcs_dbg dbg (.clk_sys_in(clk_sys_in), .resp_valid_out(rv), .resp_rdata_out(rdata),
		.link_clk_out(lclk), .link_valid_out(lval), .link_write_out(lwr), .ap_flag_out(lap),
		.idx_out(lidx), .wdata_out(lwd));
	dpcs_top uut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link_clk_in(lclk),
		.link_valid_in(lval), .link_write_in(lwr), .access_or_port_flag_in(lap),
		.link_index_in(lidx), .link_wdata_in(lwd), .port_access_instruction_in(1'b0),
		.system_power_ack_in(ack[2]), .debug_power_ack_in(ack[1]), .debug_reset_ack_in(ack[0]),
		.ap_resp_valid_in(apv), .ap_resp_read_in(apr), .ap_resp_error_in(ape),
		.ap_resp_rdata_in(aprd), .compare_match_in(ev[2]), .overrun_in(ev[3]),
		.wdata_fault_in(ev[0]), .write_dropped_in(ev[1]), .abort_write_error_clear_in(ev[4]),
		.abort_sticky_error_clear_in(ev[5]), .abort_sticky_compare_clear_in(ev[6]),
		.abort_overrun_clear_in(ev[7]), .system_power_req_out(spr), .debug_power_req_out(dpr),
		.debug_reset_req_out(drr), .transaction_counter_out(cnt), .byte_lane_mask_out(mask),
		.transfer_mode_out(mode), .overrun_detect_enable_out(ooe), .ap_select_out(aps),
		.ap_bank_out(apb), .port_bank_select_out(pbs), .resp_valid_out(rv),
		.resp_rdata_out(rdata));
	dpcs_top #(.SERIAL_VARIANT(1'b0)) uut_scan (.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in), .link_clk_in(lclk),
		.link_valid_in(lval), .link_write_in(lwr), .access_or_port_flag_in(lap),
		.link_index_in(lidx), .link_wdata_in(lwd), .port_access_instruction_in(scan_ir),
		.system_power_ack_in(ack[2]), .debug_power_ack_in(ack[1]), .debug_reset_ack_in(ack[0]),
		.ap_resp_valid_in(apv), .ap_resp_read_in(apr), .ap_resp_error_in(ape),
		.ap_resp_rdata_in(aprd), .compare_match_in(ev[2]), .overrun_in(ev[3]),
		.wdata_fault_in(ev[0]), .write_dropped_in(ev[1]), .abort_write_error_clear_in(ev[4]),
		.abort_sticky_error_clear_in(ev[5]), .abort_sticky_compare_clear_in(ev[6]),
		.abort_overrun_clear_in(ev[7]), .system_power_req_out(), .debug_power_req_out(),
		.debug_reset_req_out(), .transaction_counter_out(), .byte_lane_mask_out(),
		.transfer_mode_out(), .overrun_detect_enable_out(), .ap_select_out(),
		.ap_bank_out(), .port_bank_select_out(), .resp_valid_out(),
		.resp_rdata_out(srd));
	task automatic close_out;
		if (mismatches == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [1:0] idx, input logic [31:0] e);
		dbg.xfer(1'b0, 1'b0, idx, 32'h0, d);
		chk("read", e, d);
	endtask
	task automatic wr(input logic [1:0] idx, input logic [31:0] v);
		dbg.xfer(1'b1, 1'b0, idx, v, d);
	endtask
	// Scan instance holds its read data until its next read answer
	task automatic rd2(input logic [1:0] idx, input logic [31:0] e, input logic [31:0] es);
		rd(idx, e);
		chk("scan read", es, srd);
	endtask
	task automatic pulse(input logic [7:0] v);
		@(negedge clk_sys_in);
		ev = v;
		@(negedge clk_sys_in);
		ev = 8'h00;
	endtask
	task automatic ap(input logic err, input logic [31:0] v);
		@(negedge clk_sys_in);
		{apv, apr, ape, aprd} = {2'b11, err, v};
		@(negedge clk_sys_in);
		{apv, apr, ape, aprd} = {3'b000, ~v};
	endtask
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			close_out;
		end
	end
	initial begin
		repeat (6) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		rd(2'h0, 32'h00000000);
		ack = 3'h7;
		wr(2'h0, 32'h54ABC529);
		chk("ctrl", 32'h003D5E2D, {10'h0, spr, dpr, drr, cnt, mask, mode, ooe});
		rd(2'h0, 32'hFCABC509);
		pulse(8'h0D);
		ap(1'b1, 32'h0);
		rd(2'h0, 32'hFCABC5BB);
		pulse(8'hF0);
		rd(2'h0, 32'hFCABC509);
		pulse(8'h02);
		rd(2'h0, 32'hFCABC589);
		pulse(8'h10);
		ap(1'b0, 32'h12345678);
		rd(2'h0, 32'hFCABC549);
		rd(2'h3, 32'h12345678);
		wr(2'h0, 32'h54ABC508);
		pulse(8'h08);
		rd(2'h0, 32'hFCABC548);
		wr(2'h2, 32'h070000A1);
		chk("select", 32'h000007A1, {16'h0, aps, apb, pbs});
		rd(2'h2, 32'h00000000);
		rd(2'h0, 32'h00000000);
		wr(2'h0, 32'h00000000);
		wr(2'h2, 32'h00000000);
		rd(2'h0, 32'hFCABC548);
		dbg.xfer(1'b0, 1'b1, 2'h0, 32'h0, d);
		chk("ap_ignored", 32'hXXXXXXXX, d);
		ack = 3'h0;
		repeat (3) @(negedge clk_sys_in);
		rd(2'h0, 32'h54ABC548);
		rd2(2'h1, 32'h00000000, 32'h00000030);
		wr(2'h1, 32'h00000031);
		rd2(2'h1, 32'h00000000, 32'h00000001);
		scan_ir = 1'b0;
		rd2(2'h1, 32'h00000000, 32'h00000000);
		wr(2'h2, 32'h030000B5);
		scan_ir = 1'b1;
		rd2(2'h2, 32'h00000000, 32'h00000000);
		wr(2'h2, 32'h030000B5);
		rd2(2'h2, 32'h00000000, 32'h030000B0);
		close_out;
	end
endmodule
bind dpcs_top dpcs_top_asserts chk_u (.clk_sys_in, .sys_rst_in, .link_clk_in, .link_valid_in,
	.access_or_port_flag_in, .system_power_req_out, .debug_power_req_out, .debug_reset_req_out,
	.transaction_counter_out, .byte_lane_mask_out, .transfer_mode_out,
	.overrun_detect_enable_out, .ap_select_out, .ap_bank_out, .port_bank_select_out,
	.resp_valid_out, .resp_rdata_out);
